// ### pkg/press_guard_cfg.svh
// Constants for the press guard interlock
`ifndef PRESS_GUARD_CFG_SVH
`define PRESS_GUARD_CFG_SVH
`define PG_OFF 1'b0
`define PG_ON  1'b1
`endif

// ### pkg/press_guard_pkg.sv
// Types for the press guard interlock
package press_guard_pkg;
  typedef struct packed {
    logic guard_channel_a;
    logic guard_channel_b;
    logic guarded_mode_select;
    logic close_request_pedal;
    logic creep_request;
    logic creep_position_feedback;
  } guard_in_t;

  typedef struct packed {
    logic receiver_power;
    logic slow_speed_mute;
    logic pedal_request_forward;
    logic close_enable;
  } guard_out_t;

  typedef enum logic [2:0] {
    CREEP_IDLE = 3'b001,
    CREEP_WAIT = 3'b010,
    CREEP_SET  = 3'b100
  } creep_state_t;
endpackage : press_guard_pkg

// ### rtl/input_sampler.sv
// Registers the inputs once per scan cycle
`include "press_guard_cfg.svh"
module input_sampler
  import press_guard_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      rst_i,
  input  wire guard_in_t raw_i,
  output guard_in_t      smp_o
);
  guard_in_t smp_r;
  guard_in_t smp_nxt;

  always_comb begin
    smp_nxt = raw_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      smp_r <= '0;
    end else begin
      smp_r <= smp_nxt;
    end
  end

  assign smp_o = smp_r;
endmodule : input_sampler

// ### rtl/press_guard_interlock.sv
// Press guard interlock top level
`include "press_guard_cfg.svh"
module press_guard_interlock
  import press_guard_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic guard_channel_a_i,
  input  wire logic guard_channel_b_i,
  input  wire logic guarded_mode_select_i,
  input  wire logic close_request_pedal_i,
  input  wire logic creep_request_i,
  input  wire logic creep_position_feedback_i,
  output logic      receiver_power_o,
  output logic      slow_speed_mute_o,
  output logic      pedal_request_forward_o,
  output logic      close_enable_o,
  output logic      interruption_error_flag_o,
  output logic      channel_error_flag_o
);
  // ***********************************
  // Input sampling
  // ***********************************
  guard_in_t raw;
  guard_in_t smp;

  always_comb begin
    raw.guard_channel_a         = guard_channel_a_i;
    raw.guard_channel_b         = guard_channel_b_i;
    raw.guarded_mode_select     = guarded_mode_select_i;
    raw.close_request_pedal     = close_request_pedal_i;
    raw.creep_request           = creep_request_i;
    raw.creep_position_feedback = creep_position_feedback_i;
  end

  input_sampler u_sampler (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .raw_i     (raw),
    .smp_o     (smp)
  );

  // ***********************************
  // Creep sequence and outputs
  // ***********************************
  creep_state_t creep_r;
  creep_state_t creep_nxt;
  guard_out_t   out_r;
  guard_out_t   out_nxt;
  logic         fb_prev_r;
  logic         fb_prev_nxt;
  logic         int_err_r;
  logic         int_err_nxt;
  logic         ch_err_r;
  logic         ch_err_nxt;
  logic         both_hi;
  logic         both_lo;
  logic         disagree;
  logic         mode;

  always_comb begin
    mode        = smp.guarded_mode_select;
    both_hi     = smp.guard_channel_a & smp.guard_channel_b;
    both_lo     = ~smp.guard_channel_a & ~smp.guard_channel_b;
    disagree    = smp.guard_channel_a ^ smp.guard_channel_b;
    creep_nxt   = creep_r;
    fb_prev_nxt = smp.creep_position_feedback;
    int_err_nxt = int_err_r;
    ch_err_nxt  = ch_err_r;
    out_nxt     = '0;
    case (creep_r)
      CREEP_IDLE: begin
        if (mode && smp.creep_request) begin
          if (smp.creep_position_feedback && !fb_prev_r) begin
            creep_nxt = CREEP_SET;
          end else begin
            creep_nxt = CREEP_WAIT;
          end
        end
      end
      CREEP_WAIT: begin
        if (!mode || !smp.creep_request) begin
          creep_nxt = CREEP_IDLE;
        end else if (smp.creep_position_feedback && !fb_prev_r) begin
          creep_nxt = CREEP_SET;
        end
      end
      CREEP_SET: begin
        if (!mode || !smp.creep_request || !smp.creep_position_feedback) begin
          creep_nxt = CREEP_IDLE;
        end
      end
      default: begin
        creep_nxt = CREEP_IDLE;
      end
    endcase
    if (mode) begin
      out_nxt.receiver_power        = `PG_ON;
      out_nxt.pedal_request_forward = smp.close_request_pedal;
      out_nxt.slow_speed_mute       = (creep_nxt == CREEP_SET);
      out_nxt.close_enable          = smp.close_request_pedal & both_hi;
      if (both_lo) begin
        int_err_nxt = `PG_ON;
      end
      if (disagree) begin
        ch_err_nxt = `PG_ON;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      creep_r   <= CREEP_IDLE;
      out_r     <= '0;
      fb_prev_r <= `PG_OFF;
      int_err_r <= `PG_OFF;
      ch_err_r  <= `PG_OFF;
    end else begin
      creep_r   <= creep_nxt;
      out_r     <= out_nxt;
      fb_prev_r <= fb_prev_nxt;
      int_err_r <= int_err_nxt;
      ch_err_r  <= ch_err_nxt;
    end
  end

  // ***********************************
  // Error flag outputs
  // ***********************************
  logic int_flag_r;
  logic int_flag_nxt;
  logic ch_flag_r;
  logic ch_flag_nxt;

  always_comb begin
    int_flag_nxt = int_err_nxt & out_nxt.receiver_power;
    ch_flag_nxt  = ch_err_nxt & out_nxt.receiver_power;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      int_flag_r <= `PG_OFF;
      ch_flag_r  <= `PG_OFF;
    end else begin
      int_flag_r <= int_flag_nxt;
      ch_flag_r  <= ch_flag_nxt;
    end
  end

  always_comb begin
    receiver_power_o          = out_r.receiver_power;
    slow_speed_mute_o         = out_r.slow_speed_mute;
    pedal_request_forward_o   = out_r.pedal_request_forward;
    close_enable_o            = out_r.close_enable;
    interruption_error_flag_o = int_flag_r;
    channel_error_flag_o      = ch_flag_r;
  end

  // ***********************************
  // Assertions
  // ***********************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_MODE_OFF: assert property (!smp.guarded_mode_select |=>
    !receiver_power_o && !close_enable_o && !slow_speed_mute_o && !pedal_request_forward_o)
    else $error("outputs not low outside guarded mode");
  AST_RX_ON: assert property (smp.guarded_mode_select |=> receiver_power_o)
    else $error("receiver not powered in guarded mode");
  AST_ENABLE: assert property (smp.guarded_mode_select && smp.close_request_pedal
    && smp.guard_channel_a && smp.guard_channel_b |=> close_enable_o)
    else $error("close enable missing");
  AST_PEDAL: assert property (smp.guarded_mode_select && smp.close_request_pedal
    |=> pedal_request_forward_o)
    else $error("pedal request not forwarded");
  AST_WAIT_FB: assert property (creep_r == CREEP_WAIT && !smp.creep_position_feedback
    |=> !slow_speed_mute_o)
    else $error("mute before feedback");
  AST_MUTE_RISE: assert property (creep_r == CREEP_WAIT && smp.guarded_mode_select
    && smp.creep_request && $rose(smp.creep_position_feedback) |=> slow_speed_mute_o)
    else $error("mute missing after feedback rise");
  AST_INTERRUPT: assert property (smp.guarded_mode_select && !smp.guard_channel_a
    && !smp.guard_channel_b |=> !close_enable_o && receiver_power_o && int_err_r)
    else $error("interruption not handled");
  AST_DISAGREE: assert property (smp.guarded_mode_select
    && (smp.guard_channel_a != smp.guard_channel_b) |=> !close_enable_o && ch_err_r)
    else $error("channel fault not handled");
  AST_GUARD_HIGH: assert property ((slow_speed_mute_o || pedal_request_forward_o)
    |-> receiver_power_o)
    else $error("high toward guard without receiver power");
  AST_STICKY: assert property (ch_err_r |=> ch_err_r)
    else $error("channel flag cleared without reset");
  AST_INT_STICKY: assert property (int_err_r |=> int_err_r)
    else $error("interruption flag cleared without reset");
  AST_NO_CREEP: assert property (!smp.creep_request |=> !slow_speed_mute_o)
    else $error("mute without creep request");
  AST_ALL_HIGH: assert property (creep_r == CREEP_SET && smp.guarded_mode_select
    && smp.close_request_pedal && smp.creep_request && smp.creep_position_feedback
    && smp.guard_channel_a && smp.guard_channel_b
    |=> receiver_power_o && slow_speed_mute_o && pedal_request_forward_o && close_enable_o)
    else $error("outputs not all high with creep set");
  AST_CREEP_NO_FB: assert property (smp.guarded_mode_select && smp.close_request_pedal
    && smp.creep_request && !smp.creep_position_feedback
    && smp.guard_channel_a && smp.guard_channel_b
    |=> close_enable_o && pedal_request_forward_o)
    else $error("enable or pedal request lost while waiting");
  AST_INT_FLAG_OUT: assert property (smp.guarded_mode_select && !smp.guard_channel_a
    && !smp.guard_channel_b |=> interruption_error_flag_o)
    else $error("interruption flag not shown");
  AST_CH_FLAG_OUT: assert property (smp.guarded_mode_select
    && (smp.guard_channel_a != smp.guard_channel_b) |=> channel_error_flag_o)
    else $error("channel flag not shown");
  AST_FLAG_MASK: assert property (!receiver_power_o
    |-> !interruption_error_flag_o && !channel_error_flag_o)
    else $error("error flag shown without receiver power");

  // ***********************************
  // Covers
  // ***********************************
  COV_ENABLE: cover property (close_enable_o);
  COV_MUTE: cover property (slow_speed_mute_o && close_enable_o);
  COV_INT: cover property ($rose(int_err_r));
  COV_CH: cover property ($rose(ch_err_r));
  COV_JOINT_RISE: cover property (creep_r == CREEP_IDLE ##1 creep_r == CREEP_SET);
endmodule : press_guard_interlock

// ### test/guard_partner.sv
// Model of the optical guard device at the block's far side
module guard_partner (
  input  wire logic receiver_power_i,
  input  wire logic slow_speed_mute_i,
  input  wire logic pedal_request_forward_i,
  input  wire logic beam_clear_i,
  input  wire logic fault_i,
  output logic      guard_channel_a_o,
  output logic      guard_channel_b_o,
  output logic      drive_unpowered_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fault: one channel high, one low
  assign guard_channel_a_o = beam_clear_i | fault_i;
  assign guard_channel_b_o = beam_clear_i & ~fault_i;
  // High toward guard inputs with receiver off
  assign drive_unpowered_o = ~receiver_power_i &
                             (slow_speed_mute_i | pedal_request_forward_i);
endmodule : guard_partner

// ### test/tb_top.sv
// Self-checking bench for the press guard interlock
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_i, mode, pedal, creep, fb, beam, fault;
  logic ch_a, ch_b, rp, mute, pfwd, en, ierr, cerr, bad;
  int   n_errors, checks, cyc;
  typedef struct {logic [5:0] in; logic [5:0] exp;} row_t;
  // Inputs {mode,pedal,creep,fb,beam,fault}; outputs {rp,mute,pfwd,en,ierr,cerr}
  row_t rows [6] = '{'{6'h1f, 6'h00}, '{6'h22, 6'h20}, '{6'h32, 6'h2c},
                     '{6'h3a, 6'h2c}, '{6'h30, 6'h2a}, '{6'h31, 6'h29}};
  press_guard_interlock press_guard_interlock_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .guard_channel_a_i(ch_a),
    .guard_channel_b_i(ch_b), .guarded_mode_select_i(mode),
    .close_request_pedal_i(pedal), .creep_request_i(creep),
    .creep_position_feedback_i(fb), .receiver_power_o(rp),
    .slow_speed_mute_o(mute), .pedal_request_forward_o(pfwd),
    .close_enable_o(en), .interruption_error_flag_o(ierr),
    .channel_error_flag_o(cerr));
  guard_partner guard_partner_inst (
    .receiver_power_i(rp), .slow_speed_mute_i(mute),
    .pedal_request_forward_i(pfwd), .beam_clear_i(beam), .fault_i(fault),
    .guard_channel_a_o(ch_a), .guard_channel_b_o(ch_b),
    .drive_unpowered_o(bad));
  // ****************
  // Clock and watchdog
  // ****************
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (!rst_i && bad === 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t high toward guard while unpowered", $time);
    end
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [5:0] e, input string m);
    checks++;
    if ({rp, mute, pfwd, en, ierr, cerr} !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic run(input logic [5:0] v);
    @(posedge clk_sys_i) {mode, pedal, creep, fb, beam, fault} <= v;
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask : run
  task automatic rst;
    @(posedge clk_sys_i) begin
      rst_i <= 1'b1;
      {mode, pedal, creep, fb, beam, fault} <= 6'h00;
    end
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask : rst
  task automatic finish_test;
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // ****************
  // Sequence
  // ****************
  initial begin
    n_errors = 0;
    checks = 0;
    cyc = 0;
    rst_i = 1'b1;
    {mode, pedal, creep, fb, beam, fault} = 6'h32;
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk(6'h00, "outputs not low in reset");
    for (int i = 0; i < 6; i++) begin
      rst();
      run(rows[i].in); chk(rows[i].exp, "row mismatch");
    end
    rst();
    run(6'h3a); chk(6'h2c, "creep wait");
    run(6'h3e); chk(6'h3c, "creep set");
    run(6'h3a); chk(6'h2c, "mute not off");
    run(6'h30); chk(6'h2a, "interrupt");
    run(6'h32); chk(6'h2e, "flag cleared");
    run(6'h12); chk(6'h00, "mode off");
    rst();
    run(6'h32); chk(6'h2c, "flag after reset");
    run(6'h3e); chk(6'h3c, "mute on joint rise");
    finish_test();
  end
endmodule : tb_top
